// File: video_sync_clamp_control.sv
// sync input, slicer, clamp, coast and regenerated sync outputs of the digitizer
// assumes byte-wide register port, all pins synchronous to the 20 MHz clk
//
// Overview of operation
// - act on leading hsync edge, polarity selectable
// - selected edge is timing and clock reference
// - slicer threshold 10..330 mV, default 150
// - sliced green sync output is non-inverted
// - external clamp used only when enabled
// - otherwise clamp counted from hsync trailing edge
// - clamp polarity bit sets active clamp level
// - coast freezes pixel clock frequency and phase
// - coast polarity bit, defaults to one
// - hsync out phase aligned, programmable polarity/width
// - vsync out phase aligned, programmable polarity
// - vsync placement and duration kept from source
// - slicer pin: comparator or delayed hsync
// - slicer output gets no further processing
// - phase shift moves data, clock, hsync together
module video_sync_clamp_control
    import video_sync_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                clk_en,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_we,
    output logic      [7:0]          reg_rdata,
    // sync and control pins from the source
    input  wire logic                hsync_in,
    input  wire logic                vsync_in,
    input  wire logic [9:0]          green_sync_in,
    input  wire logic                clamp_in,
    input  wire logic                coast_in,
    input  wire logic [DATA_W-1:0]   pixel_data_in,
    // outputs to display logic
    output logic                     horiz_sync_out,
    output logic                     vert_sync_out,
    output logic                     green_slicer_out,
    output logic                     pixel_data_clock_out,
    output logic      [DATA_W-1:0]   pixel_data_out,
    // status
    output logic                     clamp_active,
    output logic                     coast_active,
    output logic                     pll_ref_pulse,
    output logic      [PERIOD_W-1:0] line_period
);
    // configuration registers
    logic [7:0] hs_cfg_q, hs_cfg_d;
    logic [7:0] cl_cfg_q, cl_cfg_d;
    logic [7:0] thr_q, thr_d;
    logic [7:0] hs_w_q, hs_w_d;
    logic [7:0] oc_q, oc_d;
    logic [7:0] cl_dly_q, cl_dly_d;
    logic [7:0] cl_dur_q, cl_dur_d;
    logic [7:0] ph_q, ph_d;
    logic [7:0] rdata_d;

    always_comb begin
        hs_cfg_d = hs_cfg_q;
        cl_cfg_d = cl_cfg_q;
        thr_d    = thr_q;
        hs_w_d   = hs_w_q;
        oc_d     = oc_q;
        cl_dly_d = cl_dly_q;
        cl_dur_d = cl_dur_q;
        ph_d     = ph_q;
        if (reg_we) begin
            case (reg_addr)
                HSYNC_CFG_ADDR:   hs_cfg_d = reg_wdata;
                CLAMP_CFG_ADDR:   cl_cfg_d = reg_wdata;
                THRESH_ADDR:      thr_d    = reg_wdata;
                HS_WIDTH_ADDR:    hs_w_d   = reg_wdata;
                OUT_CTRL_ADDR:    oc_d     = reg_wdata;
                CLAMP_DELAY_ADDR: cl_dly_d = reg_wdata;
                CLAMP_DUR_ADDR:   cl_dur_d = reg_wdata;
                PHASE_ADDR:       ph_d     = reg_wdata;
                default:          ph_d     = ph_q;
            endcase
        end
        case (reg_addr)
            HSYNC_CFG_ADDR:   rdata_d = hs_cfg_q;
            CLAMP_CFG_ADDR:   rdata_d = cl_cfg_q;
            THRESH_ADDR:      rdata_d = thr_q;
            HS_WIDTH_ADDR:    rdata_d = hs_w_q;
            OUT_CTRL_ADDR:    rdata_d = oc_q;
            CLAMP_DELAY_ADDR: rdata_d = cl_dly_q;
            CLAMP_DUR_ADDR:   rdata_d = cl_dur_q;
            PHASE_ADDR:       rdata_d = ph_q;
            default:          rdata_d = UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_cfg_q  <= HSYNC_CFG_RST;
            cl_cfg_q  <= CLAMP_CFG_RST;
            thr_q     <= THRESH_RST;
            hs_w_q    <= HS_WIDTH_RST;
            oc_q      <= OUT_CTRL_RST;
            cl_dly_q  <= CLAMP_DELAY_RST;
            cl_dur_q  <= CLAMP_DUR_RST;
            ph_q      <= PHASE_RST;
            reg_rdata <= UNMAPPED_DATA;
        end else if (clk_en) begin
            hs_cfg_q  <= hs_cfg_d;
            cl_cfg_q  <= cl_cfg_d;
            thr_q     <= thr_d;
            hs_w_q    <= hs_w_d;
            oc_q      <= oc_d;
            cl_dly_q  <= cl_dly_d;
            cl_dur_q  <= cl_dur_d;
            ph_q      <= ph_d;
            reg_rdata <= rdata_d;
        end
    end

    // horizontal sync edges
    logic hs_norm;
    logic hs_lead;
    logic hs_trail;

    sync_edge_detect u_hs_edge (
        .clk         (clk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .sync_in     (hsync_in),
        .active_high (hs_cfg_q[HSYNC_POL_BIT]),
        .norm_q      (hs_norm),
        .lead_pulse  (hs_lead),
        .trail_pulse (hs_trail)
    );

    // clamp selection
    logic int_clamp;

    clamp_window_gen u_clamp (
        .clk       (clk),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .start     (hs_trail),
        .delay_cyc (cl_dly_q),
        .dur_cyc   (cl_dur_q),
        .window    (int_clamp)
    );

    logic ext_clamp;
    logic clamp_d;
    logic coast_d;

    // a grounded, disabled clamp pin is harmless because the pin is masked here
    always_comb begin
        ext_clamp = (clamp_in == cl_cfg_q[CLAMP_POL_BIT]);
        clamp_d   = cl_cfg_q[CLAMP_FN_BIT] ? ext_clamp : int_clamp;
        coast_d   = (coast_in == cl_cfg_q[COAST_POL_BIT]);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clamp_active <= 1'b0;
            coast_active <= 1'b0;
        end else if (clk_en) begin
            clamp_active <= clamp_d;
            coast_active <= coast_d;
        end
    end

    // reference for the pixel clock generator
    assign pll_ref_pulse = hs_lead & ~coast_active;

    logic [PERIOD_W-1:0] per_cnt_q, per_cnt_d;
    logic [PERIOD_W-1:0] period_d;
    logic                pclk_q, pclk_d;

    // while coasting no realignment happens, so the divider keeps its phase
    always_comb begin
        per_cnt_d = (&per_cnt_q) ? per_cnt_q : per_cnt_q + 1'b1;
        period_d  = line_period;
        pclk_d    = ~pclk_q;
        if (pll_ref_pulse) begin
            period_d  = per_cnt_q + 1'b1;
            per_cnt_d = '0;
            pclk_d    = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_q   <= '0;
            line_period <= '0;
            pclk_q      <= 1'b0;
        end else if (clk_en) begin
            per_cnt_q   <= per_cnt_d;
            line_period <= period_d;
            pclk_q      <= pclk_d;
        end
    end

    // regenerated horizontal pulse
    logic [7:0] hs_cnt_q, hs_cnt_d;
    logic       hs_level;
    logic       vs_level;

    always_comb begin
        hs_cnt_d = (hs_cnt_q != 8'h00) ? hs_cnt_q - CNT_ONE : hs_cnt_q;
        if (hs_lead) begin
            hs_cnt_d = (hs_w_q != 8'h00) ? hs_w_q : CNT_ONE;
        end
        hs_level = oc_q[OUT_HS_POL_BIT] ? (hs_cnt_q != 8'h00) : (hs_cnt_q == 8'h00);
        vs_level = oc_q[OUT_VS_POL_BIT] ? vsync_in : ~vsync_in;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_cnt_q <= 8'h00;
        end else if (clk_en) begin
            hs_cnt_q <= hs_cnt_d;
        end
    end

    // common phase delay keeps data, clock and syncs in step
    logic [CHAIN_W-1:0] chain_q [PHASE_DEPTH];
    logic [CHAIN_W-1:0] chain_d [PHASE_DEPTH];
    logic [CHAIN_W-1:0] tap;

    always_comb begin
        chain_d[0] = {vs_level, hs_level, pclk_q, pixel_data_in};
        for (int i = 1; i < PHASE_DEPTH; i++) begin
            chain_d[i] = chain_q[i-1];
        end
        tap = chain_q[ph_q[PHASE_W-1:0]];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < PHASE_DEPTH; i++) begin
                chain_q[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < PHASE_DEPTH; i++) begin
                chain_q[i] <= chain_d[i];
            end
        end
    end

    // slicer: comparator or delayed raw hsync, nothing else
    logic [HS_DELAY_STAGES-1:0] hs_dly_q, hs_dly_d;
    logic                       slice;
    logic                       slicer_d;

    always_comb begin
        hs_dly_d = {hs_dly_q[HS_DELAY_STAGES-2:0], hsync_in};
        slice    = (green_sync_in >= thresh_mv(thr_q));
        slicer_d = oc_q[OUT_SLICE_SEL_BIT] ? hs_dly_q[HS_DELAY_STAGES-1] : slice;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_dly_q             <= '0;
            green_slicer_out     <= 1'b0;
            horiz_sync_out       <= 1'b0;
            vert_sync_out        <= 1'b0;
            pixel_data_clock_out <= 1'b0;
            pixel_data_out       <= '0;
        end else if (clk_en) begin
            hs_dly_q             <= hs_dly_d;
            green_slicer_out     <= slicer_d;
            {vert_sync_out, horiz_sync_out, pixel_data_clock_out, pixel_data_out} <= tap;
        end
    end

    ext_clamp_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && !cl_cfg_q[CLAMP_FN_BIT] |=> clamp_active == $past(int_clamp))
        else $error("clamp pin honoured while disabled");

    ext_clamp_pol_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && cl_cfg_q[CLAMP_FN_BIT] |=> clamp_active == ($past(clamp_in) == $past(cl_cfg_q[CLAMP_POL_BIT])))
        else $error("external clamp level misread");

    coast_blocks_ref_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && coast_active |=> pclk_q != $past(pclk_q))
        else $error("pixel clock realigned while coasting");

    coast_hold_period_a: assert property (@(posedge clk) disable iff (!arst_n)
        coast_active && $past(coast_active) |-> $stable(line_period))
        else $error("period changed during coast");

    thresh_range_a: assert property (@(posedge clk) disable iff (!arst_n)
        thresh_mv(thr_q) >= 10'h00A && thresh_mv(thr_q) <= 10'h14A)
        else $error("slicer threshold out of range");

    slicer_path_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en |=> green_slicer_out == $past(slicer_d))
        else $error("slicer output not from selected source");

    hs_pulse_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        hs_lead |=> hs_cnt_q != 8'h00)
        else $error("hsync pulse not started on leading edge");

    zero_phase_align_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && ph_q == PHASE_RST ##1 clk_en && ph_q == PHASE_RST |=> horiz_sync_out == $past(hs_level, 2))
        else $error("hsync output misaligned at zero phase");

    cover_coast_c:    cover property (@(posedge clk) disable iff (!arst_n) $rose(coast_active));
    cover_ext_clamp_c: cover property (@(posedge clk) disable iff (!arst_n)
        cl_cfg_q[CLAMP_FN_BIT] && $rose(clamp_active));
    cover_ref_c:      cover property (@(posedge clk) disable iff (!arst_n) pll_ref_pulse);

endmodule : video_sync_clamp_control

// File: video_sync_pkg.sv
// constants shared by the sync/clamp control block and its helper modules
// assumes a single 20 MHz clock domain with all pins synchronous to it
package video_sync_pkg;

    // register map on the configuration port
    localparam logic [7:0] HSYNC_CFG_ADDR   = 8'h0E;
    localparam logic [7:0] CLAMP_CFG_ADDR   = 8'h0F;
    localparam logic [7:0] THRESH_ADDR      = 8'h10;
    localparam logic [7:0] HS_WIDTH_ADDR    = 8'h11;
    localparam logic [7:0] OUT_CTRL_ADDR    = 8'h12;
    localparam logic [7:0] CLAMP_DELAY_ADDR = 8'h13;
    localparam logic [7:0] CLAMP_DUR_ADDR   = 8'h14;
    localparam logic [7:0] PHASE_ADDR       = 8'h15;
    localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

    // field positions
    localparam int HSYNC_POL_BIT     = 6;
    localparam int CLAMP_FN_BIT      = 7;
    localparam int CLAMP_POL_BIT     = 6;
    localparam int COAST_POL_BIT     = 3;
    localparam int OUT_HS_POL_BIT    = 0;
    localparam int OUT_VS_POL_BIT    = 1;
    localparam int OUT_SLICE_SEL_BIT = 2;

    // reset values
    localparam logic [7:0] HSYNC_CFG_RST   = 8'h00;
    localparam logic [7:0] CLAMP_CFG_RST   = 8'h48;
    localparam logic [7:0] THRESH_RST      = 8'h0F;
    localparam logic [7:0] HS_WIDTH_RST    = 8'h20;
    localparam logic [7:0] OUT_CTRL_RST    = 8'h03;
    localparam logic [7:0] CLAMP_DELAY_RST = 8'h08;
    localparam logic [7:0] CLAMP_DUR_RST   = 8'h14;
    localparam logic [7:0] PHASE_RST       = 8'h00;

    // slicer threshold: code times step, code limited to 1..33
    localparam logic [9:0] THRESH_STEP_MV  = 10'h00A;
    localparam logic [7:0] THRESH_MIN_CODE = 8'h01;
    localparam logic [7:0] THRESH_MAX_CODE = 8'h21;

    // datapath shaping
    localparam int         HS_DELAY_STAGES = 2;
    localparam int         PHASE_DEPTH     = 32;
    localparam int         PHASE_W         = 5;
    localparam int         DATA_W          = 24;
    localparam int         CHAIN_W         = DATA_W + 3;
    localparam int         PERIOD_W        = 16;
    localparam logic [7:0] CNT_ONE         = 8'h01;

    typedef enum logic [1:0] {
        CL_IDLE   = 2'b00,
        CL_DELAY  = 2'b01,
        CL_ACTIVE = 2'b10
    } clamp_state_e;

    function automatic logic [9:0] thresh_mv(input logic [7:0] code);
        logic [7:0] c;
        c = code;
        if (c < THRESH_MIN_CODE) begin
            c = THRESH_MIN_CODE;
        end else if (c > THRESH_MAX_CODE) begin
            c = THRESH_MAX_CODE;
        end
        return 10'(c * THRESH_STEP_MV);
    endfunction : thresh_mv

endpackage : video_sync_pkg

// File: sync_edge_detect.sv
// polarity normalisation and leading/trailing edge pulses for a sync input
// assumes the input is already synchronous to clk
module sync_edge_detect
    import video_sync_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // sync
    input  wire logic sync_in,
    input  wire logic active_high,
    // results
    output logic      norm_q,
    output logic      lead_pulse,
    output logic      trail_pulse
);
    logic norm_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
        norm_d = active_high ? sync_in : ~sync_in;
        prev_d = norm_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            norm_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (clk_en) begin
            norm_q <= norm_d;
            prev_q <= prev_d;
        end
    end

    // only the assertion of the normalised level counts as leading
    assign lead_pulse  = clk_en & norm_q & ~prev_q;
    assign trail_pulse = clk_en & ~norm_q & prev_q;

    lead_one_cycle_a: assert property (@(posedge clk) disable iff (!arst_n)
        lead_pulse |=> !lead_pulse)
        else $error("leading edge pulse lasted more than one cycle");

    lead_needs_assert_a: assert property (@(posedge clk) disable iff (!arst_n)
        lead_pulse |-> norm_q && !trail_pulse)
        else $error("leading edge without normalised assertion");

endmodule : sync_edge_detect

// File: clamp_window_gen.sv
// internal clamp window: programmed delay then programmed duration after a start pulse
// assumes start is a one-cycle pulse; a new start restarts the sequence
module clamp_window_gen
    import video_sync_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    // control
    input  wire logic       start,
    input  wire logic [7:0] delay_cyc,
    input  wire logic [7:0] dur_cyc,
    // result
    output logic            window
);
    clamp_state_e state_q;
    clamp_state_e state_d;
    logic [7:0]   cnt_q;
    logic [7:0]   cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (start) begin
            state_d = CL_DELAY;
            cnt_d   = delay_cyc;
        end else begin
            case (state_q)
                CL_IDLE: begin
                    cnt_d = cnt_q;
                end
                CL_DELAY: begin
                    cnt_d = cnt_q - CNT_ONE;
                    if (cnt_q <= CNT_ONE) begin
                        state_d = CL_ACTIVE;
                        cnt_d   = dur_cyc;
                    end
                end
                CL_ACTIVE: begin
                    cnt_d = cnt_q - CNT_ONE;
                    if (cnt_q <= CNT_ONE) begin
                        state_d = CL_IDLE;
                    end
                end
                default: begin
                    state_d = CL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CL_IDLE;
            cnt_q   <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign window = (state_q == CL_ACTIVE);

    start_delays_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && start && delay_cyc > CNT_ONE |=> !window)
        else $error("clamp window opened before its delay");

    window_ends_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && window && !start && cnt_q <= CNT_ONE |=> !window)
        else $error("clamp window outlived its duration");

    cover_window_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(window));

endmodule : clamp_window_gen

// File: video_source_model.sv
// source-side model: repeating hsync lines, back-porch clamp pulse and coast pin
// assumes the bench sets its polarity inputs to match the device registers
module video_source_model #(
    parameter int PER = 40,
    parameter int HW  = 4,
    parameter int CW  = 6
) (
    // clock
    input  wire logic clk,
    // control from the bench
    input  wire logic hs_pol,
    input  wire logic cl_pol,
    input  wire logic cl_en,
    input  wire logic coast_req,
    input  wire logic coast_pol,
    // pins towards the device
    output logic      hsync_in,
    output logic      clamp_in,
    output logic      coast_in
);
    timeunit 1ns;
    timeprecision 1ns;

    int   ph = 0;
    logic act_hs;
    logic act_cl;

    always @(posedge clk) begin
        ph <= #1 (ph == PER - 1) ? 0 : ph + 1;
    end

    assign act_hs   = ph < HW;
    // clamp only while the reference level is present, just after the sync pulse
    assign act_cl   = (ph >= HW + 2) && (ph < HW + 2 + CW);
    assign hsync_in = act_hs ? hs_pol : !hs_pol;
    // a disabled clamp pin sits grounded
    assign clamp_in = cl_en & (act_cl ? cl_pol : !cl_pol);
    // an idle coast pin sits at the level the polarity bit calls inactive
    assign coast_in = coast_req ? coast_pol : !coast_pol;
endmodule : video_source_model

// File: tb.sv
// self-checking bench for the sync and clamp control block
// assumes the source model drives hsync, clamp and coast; the bench drives the rest
module tb
    import video_sync_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PER = 40;
    localparam int HW  = 4;
    localparam int CW  = 6;

    logic                clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_we = 1'b0, vsync_in = 1'b0;
    logic [7:0]          reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [9:0]          green_sync_in = 10'h000;
    logic [DATA_W-1:0]   pixel_data_in = '0, pixel_data_out;
    logic                hs_pol = 1'b0, cl_pol = 1'b1, cl_en = 1'b0, coast_req = 1'b0, coast_pol = 1'b1;
    logic                hsync_in, clamp_in, coast_in, horiz_sync_out, vert_sync_out, green_slicer_out;
    logic                pixel_data_clock_out, clamp_active, coast_active, pll_ref_pulse;
    logic [PERIOD_W-1:0] line_period;
    int                  n_mismatch = 0, checked = 0, d0, e0, d5, e5;
    logic                cnt_on = 1'b0;
    // counts: reference, hsync out, clamp, vsync out, slicer, hsync in, pixel clock
    int                  cnt [7];
    logic [7:0]          rst_tab [8] = '{HSYNC_CFG_RST, CLAMP_CFG_RST, THRESH_RST, HS_WIDTH_RST,
                                         OUT_CTRL_RST, CLAMP_DELAY_RST, CLAMP_DUR_RST, PHASE_RST};
    logic [7:0]          sc [8] = '{8'h0F, 8'h0F, 8'h21, 8'h21, 8'h00, 8'h00, 8'h30, 8'h30};
    logic [9:0]          sl [8] = '{10'h096, 10'h095, 10'h14A, 10'h149, 10'h00A, 10'h009, 10'h14A, 10'h149};
    logic                se [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    always #25 clk = ~clk;

    video_sync_clamp_control dut_u (
        .clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
        .hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_in(green_sync_in),
        .clamp_in(clamp_in), .coast_in(coast_in), .pixel_data_in(pixel_data_in),
        .horiz_sync_out(horiz_sync_out), .vert_sync_out(vert_sync_out),
        .green_slicer_out(green_slicer_out), .pixel_data_clock_out(pixel_data_clock_out),
        .pixel_data_out(pixel_data_out), .clamp_active(clamp_active), .coast_active(coast_active),
        .pll_ref_pulse(pll_ref_pulse), .line_period(line_period)
    );

    video_source_model #(.PER(PER), .HW(HW), .CW(CW)) src_u (
        .clk(clk), .hs_pol(hs_pol), .cl_pol(cl_pol), .cl_en(cl_en), .coast_req(coast_req),
        .coast_pol(coast_pol), .hsync_in(hsync_in), .clamp_in(clamp_in), .coast_in(coast_in)
    );

    // sampled mid-cycle, where every registered output has settled
    always @(negedge clk) begin
        if (cnt_on) begin
            cnt[0] += pll_ref_pulse;
            cnt[1] += horiz_sync_out;
            cnt[2] += clamp_active;
            cnt[3] += vert_sync_out;
            cnt[4] += green_slicer_out;
            cnt[5] += hsync_in;
            cnt[6] += pixel_data_clock_out;
        end
    end

    task automatic conclude;
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(posedge clk) #1;
        reg_we = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        reg_addr = a;
        @(posedge clk) #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk

    // counts over n cycles, whole lines for the line checks, so their result does not depend on where the window starts
    task automatic win(input int n);
        @(posedge clk) #1;
        foreach (cnt[j]) begin
            cnt[j] = 0;
        end
        cnt_on = 1'b1;
        repeat (n) @(posedge clk);
        #1 cnt_on = 1'b0;
    endtask : win

    task automatic lat(output int dv, output int dd);
        logic              vs0;
        logic [DATA_W-1:0] pd0;
        @(posedge clk) #1;
        vs0           = vert_sync_out;
        pd0           = pixel_data_out;
        vsync_in      = ~vsync_in;
        pixel_data_in = ~pixel_data_in;
        dv            = -1;
        dd            = -1;
        for (int k = 1; k <= 45; k++) begin
            @(posedge clk) #1;
            if (dv < 0 && vert_sync_out !== vs0) dv = k;
            if (dd < 0 && pixel_data_out !== pd0) dd = k;
        end
    endtask : lat

    initial begin
        #(20000 * 50);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk(HSYNC_CFG_ADDR + 8'(i), rst_tab[i]);
        end
        wr(8'h20, 8'h5A);
        rd_chk(8'h20, UNMAPPED_DATA);
        wr(HS_WIDTH_ADDR, 8'h05);
        // both leading-edge senses, with hsync out of either polarity
        for (int p = 0; p < 2; p++) begin
            wr(HSYNC_CFG_ADDR, p ? 8'h40 : 8'h00);
            wr(OUT_CTRL_ADDR, p ? 8'h03 : 8'h02);
            hs_pol = p[0];
            repeat (3 * PER) @(posedge clk);
            win(4 * PER);
            chk(16'(cnt[0]), 16'h0004);
            chk(line_period, 16'(PER));
            chk(16'(cnt[1]), p ? 16'h0014 : 16'(4 * (PER - 5)));
        end
        for (int p = 0; p < 2; p++) begin
            wr(CLAMP_CFG_ADDR, p ? 8'h48 : 8'h40);
            coast_pol = p[0];
            coast_req = 1'b1;
            repeat (PER) @(posedge clk);
            win(4 * PER);
            chk(16'(cnt[0]), 16'h0000);
            chk({15'h0000, coast_active}, 16'h0001);
            chk(16'(cnt[6]), 16'(2 * PER));
            coast_req = 1'b0;
            repeat (4) @(posedge clk);
            #1 chk({15'h0000, coast_active}, 16'h0000);
        end
        // clamp pin toggles while the function is off; it must be ignored
        wr(CLAMP_DUR_ADDR, 8'h05);
        cl_en = 1'b1;
        repeat (2 * PER) @(posedge clk);
        win(4 * PER);
        chk(16'(cnt[2]), 16'h0014);
        for (int p = 0; p < 2; p++) begin
            wr(CLAMP_CFG_ADDR, p ? 8'hC8 : 8'h88);
            cl_pol = p[0];
            repeat (2 * PER) @(posedge clk);
            win(4 * PER);
            chk(16'(cnt[2]), 16'(4 * CW));
        end
        wr(CLAMP_CFG_ADDR, 8'h48);
        cl_en = 1'b0;
        wr(OUT_CTRL_ADDR, 8'h03);
        for (int i = 0; i < 8; i++) begin
            wr(THRESH_ADDR, sc[i]);
            green_sync_in = sl[i];
            repeat (3) @(posedge clk);
            #1 chk({15'h0000, green_slicer_out}, {15'h0000, se[i]});
        end
        wr(OUT_CTRL_ADDR, 8'h07);
        repeat (PER) @(posedge clk);
        win(4 * PER);
        chk(16'(cnt[4]), 16'(4 * HW));
        for (int p = 0; p < 2; p++) begin
            wr(OUT_CTRL_ADDR, p ? 8'h03 : 8'h01);
            repeat (8) @(posedge clk);
            #1 vsync_in = 1'b1;
            fork
                win(60);
                begin
                    repeat (7) @(posedge clk);
                    #1 vsync_in = 1'b0;
                end
            join
            chk(16'(cnt[3]), p ? 16'h0007 : 16'h0035);
        end
        // data and vsync must move by the phase step and keep their mutual offset
        wr(PHASE_ADDR, 8'h00);
        repeat (45) @(posedge clk);
        lat(d0, e0);
        wr(PHASE_ADDR, 8'h05);
        repeat (45) @(posedge clk);
        lat(d5, e5);
        chk(16'(d5), 16'(d0 + 5));
        chk(16'(e5 - d5), 16'(e0 - d0));
        conclude();
    end
endmodule : tb
